// ### ctr16_timer.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Sixteen-bit up counter behind a programmable sixteen-bit prescaler.
// - Timer mode counts clock cycles; counter mode counts external transitions.
// - Capture input edge loads count into capture register, optional interrupt.
// - Counter mode uses the capture input as count source.
// - Four match values compared with count; optional interrupt per match.
// - Match may stop the counter, optional interrupt.
// - Match may reset the counter, optional interrupt.
// - Each match output clears, sets, toggles or holds on its match.
// - PWM mode drives match outputs as single-edge PWM from match values.
// - Instances differ only in base address and in OUTPUTS, the number of match outputs driven.
// - Count advances once every prescale limit plus one ticks (clock cycles in timer mode, selected edges in counter mode).
// - A tick with prescale count already at limit increments count and clears prescale.
// - Interrupt flags show five pending sources; writing ones clears them.
// - Capture control selects capture edges and capture interrupt.
module ctr16_timer
    import ctr16_pkg::*;
#(
    parameter int OUTPUTS = NUM_OUTPUTS
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CAPTURE_INPUT_I,
    output logic [2:0] MATCH_OUTPUTS_O,
    output logic IRQ_O
);

    // ==========================================================
    // Register state
    logic [NUM_IRQ-1:0] interrupt_flags;
    logic [NUM_IRQ-1:0] interrupt_mask;
    logic [1:0] timer_control;
    logic [15:0] timer_count;
    logic [15:0] prescale_limit;
    logic [15:0] prescale_count;
    logic [11:0] match_control;
    logic [15:0] match_values [NUM_MATCH];
    logic [2:0] capture_control;
    logic [15:0] capture_value;
    logic [9:0] external_match_control;
    logic [1:0] count_control;
    logic [3:0] pwm_output_control;
    logic cap_sync1;
    logic cap_sync2;
    logic cap_prev;

    // ==========================================================
    // APB decode
    wire wr = PSEL_I && PENABLE_I && PWRITE_I;
    wire wr_irq = wr && (PADDR_I == OFF_INTERRUPT_FLAGS);
    wire wr_tcr = wr && (PADDR_I == OFF_TIMER_CONTROL);
    wire wr_tc = wr && (PADDR_I == OFF_TIMER_COUNT);
    wire wr_pr = wr && (PADDR_I == OFF_PRESCALE_LIMIT);
    wire wr_pc = wr && (PADDR_I == OFF_PRESCALE_COUNT);
    wire wr_mcr = wr && (PADDR_I == OFF_MATCH_CONTROL);
    wire wr_mr = wr && (PADDR_I >= OFF_MATCH_VALUE0) && (PADDR_I <= OFF_MATCH_VALUE3)
        && (PADDR_I[1:0] == 2'h0);
    wire [1:0] mr_sel = 2'((PADDR_I - OFF_MATCH_VALUE0) >> 2);
    wire wr_ccr = wr && (PADDR_I == OFF_CAPTURE_CONTROL);
    wire wr_emr = wr && (PADDR_I == OFF_EXTERNAL_MATCH_CONTROL);
    wire wr_ctcr = wr && (PADDR_I == OFF_COUNT_CONTROL);
    wire wr_pwm = wr && (PADDR_I == OFF_PWM_OUTPUT_CONTROL);
    wire wr_mask = wr && (PADDR_I == OFF_INTERRUPT_MASK);

    logic [31:0] rd_data;
    always_comb begin
        rd_data = RESET_VALUE;
        if (PADDR_I == OFF_INTERRUPT_FLAGS) begin
            rd_data[NUM_IRQ-1:0] = interrupt_flags;
        end else if (PADDR_I == OFF_TIMER_CONTROL) begin
            rd_data[1:0] = timer_control;
        end else if (PADDR_I == OFF_TIMER_COUNT) begin
            rd_data[15:0] = timer_count;
        end else if (PADDR_I == OFF_PRESCALE_LIMIT) begin
            rd_data[15:0] = prescale_limit;
        end else if (PADDR_I == OFF_PRESCALE_COUNT) begin
            rd_data[15:0] = prescale_count;
        end else if (PADDR_I == OFF_MATCH_CONTROL) begin
            rd_data[11:0] = match_control;
        end else if (wr_mr || (!PWRITE_I && (PADDR_I >= OFF_MATCH_VALUE0)
                && (PADDR_I <= OFF_MATCH_VALUE3) && (PADDR_I[1:0] == 2'h0))) begin
            rd_data[15:0] = match_values[mr_sel];
        end else if (PADDR_I == OFF_CAPTURE_CONTROL) begin
            rd_data[2:0] = capture_control;
        end else if (PADDR_I == OFF_CAPTURE_VALUE) begin
            rd_data[15:0] = capture_value;
        end else if (PADDR_I == OFF_EXTERNAL_MATCH_CONTROL) begin
            rd_data[9:0] = external_match_control;
        end else if (PADDR_I == OFF_COUNT_CONTROL) begin
            rd_data[1:0] = count_control;
        end else if (PADDR_I == OFF_PWM_OUTPUT_CONTROL) begin
            rd_data[3:0] = pwm_output_control;
        end else if (PADDR_I == OFF_INTERRUPT_MASK) begin
            rd_data[NUM_IRQ-1:0] = interrupt_mask;
        end
    end

    // The slave answers in the first access cycle; unmapped reads give zero.
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = 1'b0;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            PRDATA_O <= RESET_VALUE;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= rd_data;
        end
    end

    // ==========================================================
    // Count source and capture edge detection
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cap_sync1 <= 1'b0;
            cap_sync2 <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            cap_sync1 <= CAPTURE_INPUT_I;
            cap_sync2 <= cap_sync1;
            cap_prev <= cap_sync2;
        end
    end

    wire cap_rise = cap_sync2 && !cap_prev;
    wire cap_fall = !cap_sync2 && cap_prev;
    wire ext_edge = ((count_control == CTM_RISE) && cap_rise)
        || ((count_control == CTM_FALL) && cap_fall)
        || ((count_control == CTM_BOTH) && (cap_rise || cap_fall));
    wire tick = (count_control == CTM_TIMER) ? 1'b1 : ext_edge;
    wire running = timer_control[TCR_ENABLE_BIT] && !timer_control[TCR_RESET_BIT];
    wire prescale_done = (prescale_count == prescale_limit);
    wire advance = running && tick && prescale_done;
    wire capture_event = (capture_control[CCR_RISE_BIT] && cap_rise)
        || (capture_control[CCR_FALL_BIT] && cap_fall);

    // ==========================================================
    // Match detection
    logic [NUM_MATCH-1:0] match_hit;
    logic [NUM_MATCH-1:0] match_reset;
    logic [NUM_MATCH-1:0] match_stop;
    logic [NUM_MATCH-1:0] match_irq;
    genvar g;
    generate
        for (g = 0; g < NUM_MATCH; g++) begin : g_match
            assign match_hit[g] = advance && (timer_count == match_values[g]);
            assign match_reset[g] = match_hit[g] && match_control[3*g+MCR_RESET_BIT];
            assign match_stop[g] = match_hit[g] && match_control[3*g+MCR_STOP_BIT];
            assign match_irq[g] = match_hit[g] && match_control[3*g+MCR_INT_BIT];
        end
    endgenerate

    wire next_zero = |match_reset;
    wire [15:0] next_count = next_zero ? 16'h0000 : 16'(timer_count + 16'h0001);

    // ==========================================================
    // Counter, prescaler, control
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            timer_count <= 16'h0000;
            prescale_count <= 16'h0000;
            timer_control <= 2'h0;
        end else begin
            if (wr_tcr) begin
                timer_control <= PWDATA_I[1:0];
            end else if (|match_stop) begin
                timer_control[TCR_ENABLE_BIT] <= 1'b0;
            end
            if (timer_control[TCR_RESET_BIT]) begin
                timer_count <= 16'h0000;
                prescale_count <= 16'h0000;
            end else if (wr_tc) begin
                timer_count <= PWDATA_I[15:0];
            end else if (advance) begin
                timer_count <= next_count;
                prescale_count <= 16'h0000;
            end else if (running && tick) begin
                prescale_count <= 16'(prescale_count + 16'h0001);
            end
            if (wr_pc) begin
                prescale_count <= PWDATA_I[15:0];
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prescale_limit <= 16'h0000;
            match_control <= 12'h000;
            capture_control <= 3'h0;
            external_match_control <= 10'h000;
            count_control <= 2'h0;
            pwm_output_control <= 4'h0;
            interrupt_mask <= 5'h00;
            for (int i = 0; i < NUM_MATCH; i++) begin
                match_values[i] <= 16'h0000;
            end
        end else begin
            if (wr_pr) prescale_limit <= PWDATA_I[15:0];
            if (wr_mcr) match_control <= PWDATA_I[11:0];
            if (wr_ccr) capture_control <= PWDATA_I[2:0];
            if (wr_ctcr) count_control <= PWDATA_I[1:0];
            if (wr_pwm) pwm_output_control <= PWDATA_I[3:0];
            if (wr_mask) interrupt_mask <= PWDATA_I[NUM_IRQ-1:0];
            if (wr_mr) match_values[mr_sel] <= PWDATA_I[15:0];
            if (wr_emr) begin
                external_match_control <= PWDATA_I[9:0];
            end else begin
                for (int i = 0; i < OUTPUTS; i++) begin
                    if (match_hit[i]) begin
                        case (external_match_control[EMR_ACTION_LSB+2*i +: 2])
                            EMA_CLEAR: external_match_control[i] <= 1'b0;
                            EMA_SET: external_match_control[i] <= 1'b1;
                            EMA_TOGGLE: external_match_control[i] <= !external_match_control[i];
                            default: external_match_control[i] <= external_match_control[i];
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================================
    // Capture and interrupt flags
    wire [NUM_IRQ-1:0] irq_set = {capture_event && capture_control[CCR_INT_BIT], match_irq};
    wire [NUM_IRQ-1:0] irq_clr = wr_irq ? PWDATA_I[NUM_IRQ-1:0] : 5'h00;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            capture_value <= 16'h0000;
            interrupt_flags <= 5'h00;
        end else begin
            if (capture_event) capture_value <= timer_count;
            interrupt_flags <= (interrupt_flags & ~irq_clr) | irq_set;
        end
    end

    assign IRQ_O = |(interrupt_flags & interrupt_mask);

    // ==========================================================
    // PWM and match outputs
    logic [2:0] pwm_level;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pwm_level <= 3'h0;
            MATCH_OUTPUTS_O <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (|match_reset || timer_control[TCR_RESET_BIT]) begin
                    pwm_level[i] <= 1'b0;
                end else if (match_hit[i]) begin
                    pwm_level[i] <= 1'b1;
                end
                if (i >= OUTPUTS) begin
                    MATCH_OUTPUTS_O[i] <= 1'b0;
                end else if (pwm_output_control[i]) begin
                    MATCH_OUTPUTS_O[i] <= pwm_level[i];
                end else begin
                    MATCH_OUTPUTS_O[i] <= external_match_control[i];
                end
            end
        end
    end

    // ==========================================================
    // Checks
    AST_PRESCALE_CLEAR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        advance && !wr_pc && !wr_tc |=> prescale_count == 16'h0000)
        else $error("prescale count not cleared on advance");
    AST_COUNT_STEP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        advance && !next_zero && !wr_tc |=> timer_count == 16'($past(timer_count) + 16'h0001))
        else $error("count did not advance by one");
    AST_MATCH_RESET: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        |match_reset && !wr_tc && !timer_control[TCR_RESET_BIT] |=> timer_count == 16'h0000)
        else $error("match reset did not clear count");
    AST_MATCH_STOP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        |match_stop && !wr_tcr |=> !timer_control[TCR_ENABLE_BIT])
        else $error("match stop did not halt counter");
    AST_WRAP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        advance && timer_count == COUNT_MAX && !next_zero && !wr_tc |=> timer_count == 16'h0000)
        else $error("count did not wrap");
    AST_CAPTURE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        capture_event |=> capture_value == $past(timer_count))
        else $error("capture value wrong");
    AST_FLAG_SET_WINS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        irq_set[0] |=> interrupt_flags[0])
        else $error("match flag lost");
    AST_HOLD_STOPPED: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !running && !timer_control[TCR_RESET_BIT] && !wr_tc |=> timer_count == $past(timer_count))
        else $error("count moved while stopped");

endmodule : ctr16_timer

`default_nettype wire

// ### ctr16_pkg.sv
package ctr16_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_INTERRUPT_FLAGS = 12'h0000;
    localparam logic [11:0] OFF_TIMER_CONTROL = 12'h0004;
    localparam logic [11:0] OFF_TIMER_COUNT = 12'h0008;
    localparam logic [11:0] OFF_PRESCALE_LIMIT = 12'h000C;
    localparam logic [11:0] OFF_PRESCALE_COUNT = 12'h0010;
    localparam logic [11:0] OFF_MATCH_CONTROL = 12'h0014;
    localparam logic [11:0] OFF_MATCH_VALUE0 = 12'h0018;
    localparam logic [11:0] OFF_MATCH_VALUE3 = 12'h0024;
    localparam logic [11:0] OFF_CAPTURE_CONTROL = 12'h0028;
    localparam logic [11:0] OFF_CAPTURE_VALUE = 12'h002C;
    localparam logic [11:0] OFF_EXTERNAL_MATCH_CONTROL = 12'h003C;
    localparam logic [11:0] OFF_COUNT_CONTROL = 12'h0070;
    localparam logic [11:0] OFF_PWM_OUTPUT_CONTROL = 12'h0074;
    localparam logic [11:0] OFF_INTERRUPT_MASK = 12'h0078;

    // ==========================================================
    // Field positions and widths
    localparam int NUM_MATCH = 4;
    localparam int NUM_OUTPUTS = 3;
    localparam int NUM_IRQ = 5;
    localparam int IRQ_CAPTURE_BIT = 4;
    localparam int TCR_ENABLE_BIT = 0;
    localparam int TCR_RESET_BIT = 1;
    localparam int MCR_INT_BIT = 0;
    localparam int MCR_RESET_BIT = 1;
    localparam int MCR_STOP_BIT = 2;
    localparam int CCR_RISE_BIT = 0;
    localparam int CCR_FALL_BIT = 1;
    localparam int CCR_INT_BIT = 2;
    localparam int EMR_ACTION_LSB = 4;

    // External match actions.
    localparam logic [1:0] EMA_NOTHING = 2'h0;
    localparam logic [1:0] EMA_CLEAR = 2'h1;
    localparam logic [1:0] EMA_SET = 2'h2;
    localparam logic [1:0] EMA_TOGGLE = 2'h3;

    // Count source modes.
    localparam logic [1:0] CTM_TIMER = 2'h0;
    localparam logic [1:0] CTM_RISE = 2'h1;
    localparam logic [1:0] CTM_FALL = 2'h2;
    localparam logic [1:0] CTM_BOTH = 2'h3;

    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

endpackage : ctr16_pkg

// ### ctr16_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ctr16_pkg::*;
();
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic cap = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic [2:0] mo;
    wire logic irq;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [31:0] a;
    int t0;
    int t1;

    ctr16_timer #(.OUTPUTS(3)) uut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .CAPTURE_INPUT_I(cap), .MATCH_OUTPUTS_O(mo), .IRQ_O(irq));

    initial begin
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // ==========================================================
    // Bus cycles and comparisons.
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr

    task automatic rdw(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0000_0000);
    endtask : rdw

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < 4000);
        chk_pin(irq, 1'b1);
        t = cyc;
    endtask : wait_irq

    task automatic pin(input logic v);
        @(posedge clk);
        cap <= v;
        repeat (8) @(posedge clk);
    endtask : pin

    task automatic idle;
        wr(OFF_TIMER_CONTROL, 32'h0000_0002);
        wr(OFF_TIMER_CONTROL, 32'h0000_0000);
        wr(OFF_MATCH_CONTROL, 32'h0000_0000);
        wr(OFF_PRESCALE_LIMIT, 32'h0000_0000);
        wr(OFF_INTERRUPT_FLAGS, 32'h0000_001F);
    endtask : idle

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        logic [11:0] regs [8] = '{OFF_INTERRUPT_FLAGS, OFF_TIMER_CONTROL, OFF_TIMER_COUNT,
            OFF_PRESCALE_COUNT, OFF_CAPTURE_VALUE, OFF_COUNT_CONTROL,
            OFF_PWM_OUTPUT_CONTROL, 12'h040};
        wr(12'h040, 32'h0000_1234);
        foreach (regs[i]) begin
            rdw(regs[i]);
            chk_word(rd, RESET_VALUE);
        end
        chk_pin(pslverr, 1'b0);
        chk_pin(pready, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_period;
        idle;
        wr(OFF_PRESCALE_LIMIT, 32'h0000_0003);
        wr(OFF_MATCH_VALUE0, 32'h0000_0009);
        wr(OFF_MATCH_CONTROL, 32'h0000_0003);
        wr(OFF_INTERRUPT_MASK, 32'h0000_001F);
        wr(OFF_TIMER_CONTROL, 32'h0000_0001);
        wait_irq(t0);
        wr(OFF_INTERRUPT_FLAGS, 32'h0000_0001);
        wait_irq(t1);
        chk_word(32'(t1 - t0), 32'h0000_0028);
        $display("test period done");
    endtask : t_period

    task automatic t_wrap_stop;
        idle;
        wr(OFF_TIMER_COUNT, 32'h0000_FFFE);
        wr(OFF_MATCH_VALUE0 + 12'h008, 32'h0000_0001);
        wr(OFF_MATCH_CONTROL, 32'h0000_0040);
        wr(OFF_TIMER_CONTROL, 32'h0000_0001);
        wait_irq(t0);
        rdw(OFF_INTERRUPT_FLAGS);
        chk_word(rd, 32'h0000_0004);
        rdw(OFF_TIMER_COUNT);
        a = rd;
        rdw(OFF_TIMER_COUNT);
        chk_pin(rd !== a, 1'b1);
        idle;
        wr(OFF_MATCH_VALUE0 + 12'h004, 32'h0000_0004);
        wr(OFF_MATCH_CONTROL, 32'h0000_0028);
        wr(OFF_TIMER_CONTROL, 32'h0000_0001);
        wait_irq(t0);
        rdw(OFF_TIMER_COUNT);
        a = rd;
        repeat (20) @(posedge clk);
        rdw(OFF_TIMER_COUNT);
        chk_word(rd, a);
        rdw(OFF_TIMER_CONTROL);
        chk_word(rd, 32'h0000_0000);
        $display("test wrap and stop done");
    endtask : t_wrap_stop

    task automatic t_capture;
        idle;
        wr(OFF_TIMER_CONTROL, 32'h0000_0001);
        wr(OFF_CAPTURE_CONTROL, 32'h0000_0006);
        pin(1'b1);
        rdw(OFF_INTERRUPT_FLAGS);
        chk_word(rd, 32'h0000_0000);
        pin(1'b0);
        rdw(OFF_INTERRUPT_FLAGS);
        chk_word(rd, 32'h0000_0010);
        wr(OFF_INTERRUPT_FLAGS, 32'h0000_0010);
        wr(OFF_CAPTURE_CONTROL, 32'h0000_0005);
        wr(OFF_INTERRUPT_MASK, 32'h0000_0000);
        rdw(OFF_TIMER_COUNT);
        a = rd;
        pin(1'b1);
        rdw(OFF_INTERRUPT_FLAGS);
        chk_word(rd, 32'h0000_0010);
        chk_pin(irq, 1'b0);
        rdw(OFF_CAPTURE_VALUE);
        chk_pin(rd > a && rd < a + 32'h0000_0014, 1'b1);
        wr(OFF_INTERRUPT_MASK, 32'h0000_0010);
        @(negedge clk);
        chk_pin(irq, 1'b1);
        wr(OFF_INTERRUPT_FLAGS, 32'h0000_0010);
        @(negedge clk);
        chk_pin(irq, 1'b0);
        wr(OFF_CAPTURE_CONTROL, 32'h0000_0000);
        wr(OFF_INTERRUPT_MASK, 32'h0000_001F);
        pin(1'b0);
        $display("test capture done");
    endtask : t_capture

    task automatic t_count_modes;
        for (int m = 1; m < 4; m++) begin
            idle;
            wr(OFF_COUNT_CONTROL, 32'(m));
            wr(OFF_TIMER_CONTROL, 32'h0000_0001);
            repeat (4) begin
                pin(1'b1);
                pin(1'b0);
            end
            wr(OFF_TIMER_CONTROL, 32'h0000_0000);
            rdw(OFF_TIMER_COUNT);
            chk_word(rd, (m == 3) ? 32'h0000_0008 : 32'h0000_0004);
        end
        wr(OFF_COUNT_CONTROL, 32'h0000_0000);
        $display("test count modes done");
    endtask : t_count_modes

    task automatic t_ext_match;
        logic [1:0] act [4] = '{EMA_SET, EMA_CLEAR, EMA_TOGGLE, EMA_NOTHING};
        logic [3:0] ini = 4'b1110;
        logic [3:0] exp = 4'b1001;
        for (int i = 0; i < 4; i++) begin
            idle;
            wr(OFF_MATCH_VALUE0, 32'h0000_0003);
            wr(OFF_MATCH_CONTROL, 32'h0000_0005);
            wr(OFF_EXTERNAL_MATCH_CONTROL, {26'h000_0000, act[i], 3'b000, ini[i]});
            wr(OFF_TIMER_CONTROL, 32'h0000_0001);
            wait_irq(t0);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk_pin(mo[0], exp[i]);
            chk_pin(mo[2], 1'b0);
        end
        $display("test external match done");
    endtask : t_ext_match

    task automatic t_pwm;
        int highs;
        highs = 0;
        idle;
        wr(OFF_EXTERNAL_MATCH_CONTROL, 32'h0000_0000);
        wr(OFF_MATCH_VALUE0 + 12'h00C, 32'h0000_0013);
        wr(OFF_MATCH_VALUE0 + 12'h004, 32'h0000_0005);
        wr(OFF_MATCH_CONTROL, 32'h0000_0400);
        wr(OFF_PWM_OUTPUT_CONTROL, 32'h0000_0002);
        wr(OFF_TIMER_CONTROL, 32'h0000_0001);
        repeat (25) @(posedge clk);
        repeat (40) begin
            @(negedge clk);
            highs += (mo[1] === 1'b1) ? 1 : 0;
        end
        chk_word(32'(highs), 32'h0000_001C);
        $display("test pwm done");
    endtask : t_pwm

    initial begin
        repeat (20000) @(posedge clk);
        chk_pin(1'b0, 1'b1);
        results;
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_period;
        t_wrap_stop;
        t_capture;
        t_count_modes;
        t_ext_match;
        t_pwm;
        results;
    end
endmodule : testbench
`default_nettype wire
